// >>> core/dramc_ctrl.sv
// DRAM access and refresh controller: mode decode, automatic access,
// hidden refresh, refresh request and forced refresh handover.
// Assumes every input is synchronous to i_clk; refresh request pin is
// open drain, resolved outside from its output enable.
`timescale 1ns/1ps

// Overview of operation
// R1: mode 4 users refresh only in mode 0
// R2: mode 5 derives all strobes from row strobe
// R3: mode 5 reuses select and CAS pins as clocks
// R4: mode 5 access needs only row strobe low; the code also needs chip select low
// R5: selected row strobe follows row strobe input
// R6: row address held for selectable hold time
// R7: hold select high gives at least 15 ns
// R8: then column address, then column strobe low
// R9: write enable output follows write input
// R10: pure external refresh handled by system
// R11: refresh counter on outputs, increments at end
// R12: request when period clock falls unrefreshed
// R13: deselected, clock high: all strobes refresh
// R14: at most one hidden refresh per period
// R15: started hidden refresh finishes despite clock fall
// R16: system keeps chip select high during refresh
// R17: system refreshes while period clock is low
// R18: entering mode 0 drops the refresh request
// R19: system maximises period clock high time
// R20: system meets address setup before strobe
// R21: open latch strobe passes addresses through
// R22: nine bit address mux, two bit bank
// R23: two mode pins select one of four
// R24: forced refresh strobes timed by strobe clock
// R25: access end restores strobes and row address
module dramc_ctrl
    import dramc_pkg::*;
#(
    parameter int ADDR_W = ADDR_W_DEF
) (
    // Clock and reset
    input  wire logic              i_clk,
    input  wire logic              i_srst,
    // Mode pins
    input  wire logic              i_mode_bit_high,
    input  wire logic              i_mode_bit_low,
    // Access control from the system
    input  wire logic              i_row_strobe_in_n,
    input  wire logic              i_refresh_period_clock,
    input  wire logic              i_strobe_gen_clock,
    input  wire logic              i_write_in_n,
    input  wire logic              i_chip_select_n,
    input  wire logic              i_row_hold_select,
    // System address
    input  wire logic              i_addr_latch_strobe,
    input  wire logic [ADDR_W-1:0] i_row_addr_in,
    input  wire logic [ADDR_W-1:0] i_col_addr_in,
    input  wire logic              i_bank_select_lsb,
    input  wire logic              i_bank_select_msb,
    // Refresh request pin, open drain
    input  wire logic              i_refresh_req_io,
    output logic                   o_refresh_req_io,
    output logic                   o_refresh_req_io_oe,
    // DRAM side
    output logic      [ADDR_W-1:0] o_mux_addr_out,
    output logic      [BANK_N-1:0] o_row_strobe_n,
    output logic                   o_col_strobe_n,
    output logic                   o_write_en_n
);

    // ------------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------------
    if (ADDR_W < 1 || ADDR_W > 16) begin : g_bad_width
        $error("dramc_ctrl: ADDR_W must be 1 to 16");
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);

    dramc_mode_t       mode_w;
    dramc_acc_t        st_q;
    dramc_acc_t        st_d;
    logic [HOLD_W-1:0] hold_q;
    logic [HOLD_W-1:0] hold_d;
    logic [BANK_W-1:0] bank_q;
    logic [BANK_W-1:0] bank_d;
    logic [BANK_N-1:0] bank_oh;
    logic [ADDR_W-1:0] row_w;
    logic [ADDR_W-1:0] col_w;
    logic [BANK_W-1:0] bank_w;
    logic [ADDR_W-1:0] refcnt_q;
    logic [ADDR_W-1:0] addr_q;
    logic [ADDR_W-1:0] addr_d;
    logic [BANK_N-1:0] ras_q;
    logic [BANK_N-1:0] ras_d;
    logic              cas_q;
    logic              cas_d;
    logic              we_q;
    logic              we_d;
    logic              rstb_q;
    logic              pclk_q;
    logic              hid_q;
    logic              done_q;
    logic              req_q;
    logic              req_n_q;
    logic              fr_low;
    logic              fr_done;

    wire rstb      = i_row_strobe_in_n;
    wire pclk      = i_refresh_period_clock;
    wire ras_rise  = rstb & ~rstb_q;
    wire pclk_fall = pclk_q & ~pclk;
    wire pclk_rise = pclk & ~pclk_q;

    // ------------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------------
    always_comb begin
        case ({i_mode_bit_high, i_mode_bit_low}) // R23
            2'h0:    mode_w = MODE_EXT_REFRESH;
            2'h1:    mode_w = MODE_FORCED_REFRESH;
            2'h2:    mode_w = MODE_EXT_ACCESS;
            default: mode_w = MODE_AUTO_ACCESS;
        endcase
    end

    // Mode 1 with the period clock high acts as external refresh, except while forced refresh holds the strobes low
    wire ext_ref = (mode_w == MODE_EXT_REFRESH) ||
                   (mode_w == MODE_FORCED_REFRESH && pclk && !fr_low);
    wire forced_ref = (mode_w == MODE_FORCED_REFRESH) && !ext_ref;
    wire auto_mode  = (mode_w == MODE_AUTO_ACCESS);

    // ------------------------------------------------------------------
    // Address latches and forced refresh sequencer
    // ------------------------------------------------------------------
    dramc_addr_mux #(
        .ADDR_W (ADDR_W)
    ) u_addr_mux (
        .i_clk               (i_clk),
        .i_srst              (i_srst),
        .i_addr_latch_strobe (i_addr_latch_strobe),
        .i_row_addr_in       (i_row_addr_in),
        .i_col_addr_in       (i_col_addr_in),
        .i_bank              ({i_bank_select_msb, i_bank_select_lsb}),
        .o_row               (row_w),
        .o_col               (col_w),
        .o_bank              (bank_w)
    );

    dramc_forced_refresh_mode_n u_forced (
        .i_clk         (i_clk),
        .i_srst        (i_srst),
        .i_mode_forced (mode_w == MODE_FORCED_REFRESH),
        .i_pclk_high   (pclk),
        .i_gen_clk     (i_strobe_gen_clock),
        .o_ras_low     (fr_low),
        .o_done        (fr_done)
    );

    // ------------------------------------------------------------------
    // Input history for edge detection
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            rstb_q <= 1'b1;
            pclk_q <= 1'b0;
        end else begin
            rstb_q <= rstb;
            pclk_q <= pclk;
        end
    end

    // ------------------------------------------------------------------
    // Hidden refresh
    // ------------------------------------------------------------------
    // Window opens only when deselected, clock high, period unused
    wire hid_window = auto_mode && i_chip_select_n && pclk &&
                      !done_q && !hid_q && st_q == ACC_IDLE; // R13 R14
    wire hid_start  = hid_window && !rstb;

    // Once begun it ends only on the strobe input, not the clock
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            hid_q <= 1'b0;
        end else begin
            hid_q <= !rstb && (hid_q || hid_start); // R15
        end
    end

    hidden_hold_a: assert property ( // R15
        (hid_q && !rstb) |=> hid_q)
        else $error("hidden refresh dropped before strobe rose");

    hidden_once_a: assert property ( // R14
        (done_q && !pclk_rise) |=> !hid_start)
        else $error("second hidden refresh in one period");

    // ------------------------------------------------------------------
    // Refresh counter
    // ------------------------------------------------------------------
    // Counter may be cleared by pulling the pin low from outside
    wire cnt_clear = (mode_w == MODE_EXT_REFRESH ||
                      mode_w == MODE_FORCED_REFRESH) &&
                     !i_refresh_req_io && !req_q;
    wire ref_end   = (ras_rise && (ext_ref || hid_q)) || fr_done;

    always_ff @(posedge i_clk) begin
        if (i_srst || cnt_clear) begin
            refcnt_q <= '0;
        end else if (ref_end) begin
            refcnt_q <= refcnt_q + ADDR_W'(1); // R11
        end
    end

    counter_step_a: assert property ( // R11
        (ref_end && !cnt_clear) |=> refcnt_q == $past(refcnt_q) + 1'b1)
        else $error("refresh counter did not step at refresh end");

    // ------------------------------------------------------------------
    // Refresh bookkeeping and request
    // ------------------------------------------------------------------
    wire done_set = hid_start || fr_low ||
                    (ext_ref && !rstb && rstb_q);
    wire req_set  = pclk_fall && !done_q && !done_set; // R12
    wire req_clr  = (mode_w == MODE_EXT_REFRESH) || fr_low; // R18

    // A new refresh wins over the period clock rising
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            done_q <= 1'b0;
        end else begin
            done_q <= done_set || (done_q && !pclk_rise);
        end
    end

    // Set wins over clear so a request is never lost
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            req_q   <= 1'b0;
            req_n_q <= 1'b1;
        end else begin
            req_q   <= req_set || (req_q && !req_clr);
            req_n_q <= !(req_set || (req_q && !req_clr));
        end
    end

    refresh_req_a: assert property ( // R12
        (pclk_fall && !done_q && !done_set) |=> req_q)
        else $error("no request after unrefreshed period");

    req_drop_a: assert property ( // R18
        (mode_w == MODE_EXT_REFRESH && !req_set) |=> !req_q)
        else $error("request kept after entering external refresh");

    // ------------------------------------------------------------------
    // Automatic access sequencer
    // ------------------------------------------------------------------
    wire acc_start = auto_mode && !i_chip_select_n && !rstb &&
                     rstb_q && !hid_q && st_q == ACC_IDLE; // R4

    always_comb begin
        st_d   = st_q;
        hold_d = hold_q;
        if (!auto_mode || rstb) begin
            st_d = ACC_IDLE; // R25
        end else begin
            case (st_q)
                ACC_IDLE: begin
                    if (acc_start) begin
                        st_d   = ACC_ROW;
                        hold_d = (i_row_hold_select ? ROW_HOLD_LONG_CYC
                                  : ROW_HOLD_SHORT_CYC) - 1'b1; // R6 R7
                    end
                end
                ACC_ROW: begin
                    if (hold_q == '0) begin
                        st_d = ACC_COL; // R8
                    end else begin
                        hold_d = hold_q - 1'b1;
                    end
                end
                ACC_COL: st_d = ACC_CAS;
                default: st_d = st_q;
            endcase
        end
    end

    // Bank is frozen for the whole access
    assign bank_d = (st_q == ACC_IDLE) ? bank_w : bank_q;

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            st_q   <= ACC_IDLE;
            hold_q <= '0;
            bank_q <= '0;
        end else begin
            st_q   <= st_d; // R2
            hold_q <= hold_d;
            bank_q <= bank_d;
        end
    end

    for (genvar b = 0; b < BANK_N; b++) begin : g_bank
        assign bank_oh[b] = (bank_d == BANK_W'(b)); // R22
    end

    // ------------------------------------------------------------------
    // Output selection
    // ------------------------------------------------------------------
    // In mode 5 the select and CAS pins only feed refresh timing
    always_comb begin
        addr_d = row_w;
        ras_d  = BANKS_IDLE;
        cas_d  = 1'b1;
        we_d   = 1'b1;
        case (mode_w)
            MODE_EXT_ACCESS: begin
                addr_d = pclk ? row_w : col_w;
                ras_d  = rstb ? BANKS_IDLE : ~bank_oh;
                cas_d  = pclk | i_strobe_gen_clock;
                we_d   = i_write_in_n; // R9
            end
            MODE_EXT_REFRESH, MODE_FORCED_REFRESH: begin
                addr_d = refcnt_q; // R11
                ras_d  = forced_ref ? {BANK_N{~fr_low}}
                                    : {BANK_N{rstb}}; // R24
            end
            default: begin // R3
                if (hid_q || hid_window) begin
                    addr_d = refcnt_q; // R13
                    ras_d  = {BANK_N{rstb}};
                end else if (st_d != ACC_IDLE) begin
                    ras_d  = ~bank_oh; // R5
                    addr_d = (st_d == ACC_ROW) ? row_w : col_w;
                    cas_d  = (st_d != ACC_CAS); // R8
                    we_d   = i_write_in_n; // R9
                end
            end
        endcase
    end

    // All DRAM side outputs leave straight from these flip-flops
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            addr_q <= '0;
            ras_q  <= BANKS_IDLE;
            cas_q  <= 1'b1;
            we_q   <= 1'b1;
        end else begin
            addr_q <= addr_d;
            ras_q  <= ras_d;
            cas_q  <= cas_d;
            we_q   <= we_d;
        end
    end

    assign o_mux_addr_out      = addr_q;
    assign o_row_strobe_n      = ras_q;
    assign o_col_strobe_n      = cas_q;
    assign o_write_en_n        = we_q;
    assign o_refresh_req_io    = req_n_q;
    assign o_refresh_req_io_oe = req_q;

    // ------------------------------------------------------------------
    // Access checks
    // ------------------------------------------------------------------
    sequence s_acc_held;
        acc_start ##1 !rstb [*2];
    endsequence

    ras_follow_a: assert property ( // R5
        acc_start |=> ras_q == ~$past(bank_oh))
        else $error("selected row strobe did not follow input");

    row_hold_a: assert property ( // R6
        acc_start |=> addr_q == $past(row_w))
        else $error("row address not held after row strobe");

    col_addr_a: assert property ( // R8
        s_acc_held |-> addr_q == $past(col_w) && cas_q)
        else $error("column address not switched after hold");

    col_strobe_a: assert property ( // R8
        s_acc_held |=> !cas_q)
        else $error("column strobe did not fall after switch");

    access_end_a: assert property ( // R25
        (auto_mode && st_q != ACC_IDLE && rstb)
        |=> ras_q == BANKS_IDLE && cas_q)
        else $error("strobes not restored at access end");

    write_follow_a: assert property ( // R9
        (mode_w == MODE_EXT_ACCESS) |=> we_q == $past(i_write_in_n))
        else $error("write enable did not follow write input");

endmodule // dramc_ctrl

// >>> core/dramc_pkg.sv
// Shared constants and types for the DRAM access and refresh controller.
// Assumes a single 50 MHz clock; every pin is synchronous to that clock.
package dramc_pkg;

    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ           = 50;
    localparam int ROW_HOLD_LONG_NS  = 15;
    localparam int ROW_HOLD_SHORT_NS = 10;
    localparam int HOLD_W            = 4;

    // Least time in ns to whole cycles, rounded up, never below one
    function automatic int ns_min_cyc(input int ns);
        int c;
        c = (ns * CLK_MHZ + 999) / 1000;
        return (c < 1) ? 1 : c;
    endfunction

    localparam logic [HOLD_W-1:0] ROW_HOLD_LONG_CYC =
        HOLD_W'(ns_min_cyc(ROW_HOLD_LONG_NS));
    localparam logic [HOLD_W-1:0] ROW_HOLD_SHORT_CYC =
        HOLD_W'(ns_min_cyc(ROW_HOLD_SHORT_NS));

    // ------------------------------------------------------------------
    // Geometry, reset values and forced refresh edge counts
    // ------------------------------------------------------------------
    localparam int ADDR_W_DEF = 9;
    localparam int BANK_W     = 2;
    localparam int BANK_N     = 4;
    localparam logic [BANK_N-1:0] BANKS_IDLE = 4'hF;
    localparam logic [1:0] FR_FALL_EDGES = 2'h2;
    localparam logic [1:0] FR_LOW_EDGES  = 2'h2;

    // ------------------------------------------------------------------
    // Modes and access states
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_EXT_REFRESH,
        MODE_FORCED_REFRESH,
        MODE_EXT_ACCESS,
        MODE_AUTO_ACCESS
    } dramc_mode_t;

    typedef enum logic [1:0] {
        ACC_IDLE,
        ACC_ROW,
        ACC_COL,
        ACC_CAS
    } dramc_acc_t;

endpackage

// >>> core/dramc_addr_mux.sv
// Input address latches for row, column and bank select.
// Assumes the latch strobe is synchronous to the clock.
`timescale 1ns/1ps
module dramc_addr_mux
    import dramc_pkg::*;
#(
    parameter int ADDR_W = ADDR_W_DEF
) (
    // Clock and reset
    input  wire logic              i_clk,
    input  wire logic              i_srst,
    // System address
    input  wire logic              i_addr_latch_strobe,
    input  wire logic [ADDR_W-1:0] i_row_addr_in,
    input  wire logic [ADDR_W-1:0] i_col_addr_in,
    input  wire logic [BANK_W-1:0] i_bank,
    // Latched or passed address
    output logic      [ADDR_W-1:0] o_row,
    output logic      [ADDR_W-1:0] o_col,
    output logic      [BANK_W-1:0] o_bank
);

    localparam int W = 2 * ADDR_W + BANK_W;

    logic [W-1:0] in_w;
    logic [W-1:0] hold_q;
    logic [W-1:0] out_w;

    assign in_w = {i_bank, i_col_addr_in, i_row_addr_in};

    // ------------------------------------------------------------------
    // Transparent while the strobe is high, held once it falls
    // ------------------------------------------------------------------
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge i_clk) begin
            if (i_srst) begin
                hold_q[i] <= 1'b0;
            end else if (i_addr_latch_strobe) begin
                hold_q[i] <= in_w[i];
            end
        end
        assign out_w[i] = i_addr_latch_strobe ? in_w[i] : hold_q[i]; // R21
    end

    assign o_row  = out_w[ADDR_W-1:0];
    assign o_col  = out_w[2*ADDR_W-1:ADDR_W];
    assign o_bank = out_w[W-1:2*ADDR_W];

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);

    pass_through_a: assert property ( // R21
        i_addr_latch_strobe |-> (o_row == i_row_addr_in &&
                                 o_col == i_col_addr_in))
        else $error("address not passed through with latch open");

    // The value standing as the strobe falls is what must be held
    latch_hold_a: assert property ( // R21
        (i_addr_latch_strobe ##1 !i_addr_latch_strobe)
        |-> o_row == $past(i_row_addr_in) &&
            o_col == $past(i_col_addr_in))
        else $error("address not held after latch strobe fell");

endmodule // dramc_addr_mux

// >>> core/dramc_forced_refresh_mode_n.sv
// Forced refresh sequencer timed by falling edges of the strobe clock.
// Assumes the strobe generator clock is sampled at the system clock.
`timescale 1ns/1ps
module dramc_forced_refresh_mode_n
    import dramc_pkg::*;
(
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_srst,
    // Mode and timing inputs
    input  wire logic i_mode_forced,
    input  wire logic i_pclk_high,
    input  wire logic i_gen_clk,
    // Sequencer state
    output logic      o_ras_low,
    output logic      o_done
);

    logic       gen_q;
    logic       busy_q;
    logic       low_q;
    logic       spent_q;
    logic       done_q;
    logic [1:0] cnt_q;
    logic       fall_w;

    // Falling edge of the strobe generator clock
    always_ff @(posedge i_clk) begin
        gen_q <= i_srst ? 1'b0 : i_gen_clk;
    end
    assign fall_w = gen_q & ~i_gen_clk;

    // ------------------------------------------------------------------
    // Strobes drop on the second fall, rise after two more
    // ------------------------------------------------------------------
    // Leaving the mode aborts at once; only one refresh per mode entry
    always_ff @(posedge i_clk) begin
        if (i_srst || !i_mode_forced) begin
            busy_q  <= 1'b0;
            low_q   <= 1'b0;
            spent_q <= 1'b0;
            done_q  <= 1'b0;
            cnt_q   <= 2'h0;
        end else begin
            done_q <= 1'b0;
            if (!busy_q && !spent_q && !i_pclk_high) begin
                busy_q <= 1'b1;
                cnt_q  <= 2'h0;
            end else if (busy_q && fall_w) begin // R24
                if (!low_q && cnt_q == FR_FALL_EDGES - 2'h1) begin
                    low_q <= 1'b1;
                    cnt_q <= 2'h0;
                end else if (low_q && cnt_q == FR_LOW_EDGES - 2'h1) begin
                    low_q   <= 1'b0;
                    busy_q  <= 1'b0;
                    spent_q <= 1'b1;
                    done_q  <= 1'b1;
                    cnt_q   <= 2'h0;
                end else begin
                    cnt_q <= cnt_q + 2'h1;
                end
            end
        end
    end

    assign o_ras_low = low_q;
    assign o_done    = done_q;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);

    forced_drop_a: assert property ( // R24
        (busy_q && !low_q && fall_w && cnt_q == 2'h1 && i_mode_forced)
        |=> low_q)
        else $error("strobes did not drop on second falling edge");

    forced_stay_a: assert property ( // R24
        (low_q && fall_w && cnt_q == 2'h0 && i_mode_forced) |=> low_q)
        else $error("strobes rose after only one further edge");

endmodule // dramc_forced_refresh_mode_n

// >>> verification/dramc_dram_model.sv
// DRAM bank model: latches the row address on any row strobe fall and
// the column address on a column strobe fall, as the memory chips do.
// Assumes strobes and address are registered on the same clock.
`timescale 1ns/1ps
module dramc_dram_model
    import dramc_pkg::*;
(
    // Clock
    input  wire logic              i_clk,
    // DRAM pins
    input  wire logic [8:0]        i_addr,
    input  wire logic [BANK_N-1:0] i_ras_n,
    input  wire logic              i_cas_n,
    // Captured addresses
    output logic      [8:0]        o_row,
    output logic      [8:0]        o_col
);
    logic [BANK_N-1:0] ras_q;
    logic              cas_q;
    // Edge detect on the strobes; a level would miss a held address
    always_ff @(posedge i_clk) begin
        ras_q <= i_ras_n;
        cas_q <= i_cas_n;
        if ((ras_q & ~i_ras_n) != '0) begin
            o_row <= i_addr;
        end
        if (cas_q && !i_cas_n) begin
            o_col <= i_addr;
        end
    end
endmodule // dramc_dram_model

// >>> verification/dramc_ctrl_tb_top.sv
// Testbench: table of mode 5 accesses, then hidden refresh, request,
// external and forced refresh by hand.
// Assumes one 50 MHz clock and a pulled-up refresh request pin.
`timescale 1ns/1ps
module dramc_ctrl_tb_top;
    import dramc_pkg::*;
    logic       clk, srst, mh, ml, rin_n, pclk, gck, wr_n, cs_n;
    logic       hsel, lat, bk0, bk1, pin, req, oe, cas_n, we_n;
    logic [8:0] row, col, addr, m_row, m_col;
    logic [3:0] ras_n;
    int         n_mismatch = 0;
    int         n_compared = 0;
    // Bank, row, column, write input
    localparam logic [20:0] ACC [4] = '{{2'h0, 9'h000, 9'h1FF, 1'h1},
        {2'h1, 9'h1FF, 9'h000, 1'h0}, {2'h2, 9'h0A5, 9'h15A, 1'h1},
        {2'h3, 9'h123, 9'h0F0, 1'h0}};
    // Pull-up unless the device pulls the pin low
    assign pin = ~(oe & ~req);
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    dramc_ctrl u_dut (.i_clk(clk), .i_srst(srst), .i_mode_bit_high(mh),
        .i_mode_bit_low(ml), .i_row_strobe_in_n(rin_n),
        .i_refresh_period_clock(pclk), .i_strobe_gen_clock(gck),
        .i_write_in_n(wr_n), .i_chip_select_n(cs_n),
        .i_row_hold_select(hsel), .i_addr_latch_strobe(lat),
        .i_row_addr_in(row), .i_col_addr_in(col), .i_bank_select_lsb(bk0),
        .i_bank_select_msb(bk1), .i_refresh_req_io(pin),
        .o_refresh_req_io(req), .o_refresh_req_io_oe(oe),
        .o_mux_addr_out(addr), .o_row_strobe_n(ras_n),
        .o_col_strobe_n(cas_n), .o_write_en_n(we_n));
    dramc_dram_model u_mem (.i_clk(clk), .i_addr(addr), .i_ras_n(ras_n),
        .i_cas_n(cas_n), .o_row(m_row), .o_col(m_col));
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    // One strobe clock period, falling edge in the middle
    task automatic gfall();
        gck <= 1'b1;
        tick(2);
        gck <= 1'b0;
        tick(2);
    endtask
    task automatic stop_test();
        if (n_mismatch == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Cut a hang short; the whole run needs about 110 cycles
    initial begin
        repeat (2000) @(posedge clk);
        n_mismatch++;
        stop_test();
    end
    initial begin
        logic [3:0] bank_n;
        {mh, ml, rin_n, pclk, gck, wr_n, cs_n, hsel, lat} = 9'h1CF;
        {bk1, bk0, row, col} = '0;
        srst = 1'b1;
        tick(6);
        chk(addr, 9'h000);
        chk({cas_n, we_n, oe, ras_n}, 7'h6F);
        srst <= 1'b0;
        foreach (ACC[i]) begin
            {bk1, bk0, row, col, wr_n} <= ACC[i];
            cs_n <= 1'b0;
            hsel <= i[0];
            bank_n = ~(4'h1 << ACC[i][20:19]);
            tick(1);
            rin_n <= 1'b0;
            tick(5);
            chk(ras_n, bank_n);
            chk(m_row, ACC[i][18:10]);
            chk(cas_n, 1'b0);
            chk(we_n, ACC[i][0]);
            rin_n <= 1'b1;
            tick(2);
            chk(m_col, ACC[i][9:1]);
            chk({ras_n, cas_n}, 5'h1F);
            chk(addr, ACC[i][18:10]);
        end
        cs_n <= 1'b1;
        pclk <= 1'b1;
        tick(2);
        chk(addr, 9'h000);
        rin_n <= 1'b0;
        tick(2);
        chk(ras_n, 4'h0);
        pclk <= 1'b0;
        tick(3);
        chk(ras_n, 4'h0);
        rin_n <= 1'b1;
        tick(2);
        chk(oe, 1'b0);
        pclk <= 1'b1;
        tick(3);
        chk(addr, 9'h001);
        rin_n <= 1'b0;
        tick(2);
        rin_n <= 1'b1;
        tick(2);
        rin_n <= 1'b0;
        tick(2);
        chk(ras_n, 4'hF);
        rin_n <= 1'b1;
        pclk <= 1'b0;
        tick(2);
        pclk <= 1'b1;
        tick(2);
        pclk <= 1'b0;
        tick(2);
        chk({oe, pin}, 2'h2);
        mh <= 1'b0;
        ml <= 1'b0;
        tick(2);
        chk({oe, pin}, 2'h1);
        chk(addr, 9'h002);
        rin_n <= 1'b0;
        tick(3);
        chk(ras_n, 4'h0);
        rin_n <= 1'b1;
        tick(4);
        chk(addr, 9'h003);
        mh <= 1'b1;
        ml <= 1'b1;
        tick(2);
        mh <= 1'b0;
        tick(1);
        gfall();
        tick(2);
        chk(ras_n, 4'hF);
        gfall();
        tick(2);
        chk(ras_n, 4'h0);
        gfall();
        chk(ras_n, 4'h0);
        gfall();
        tick(2);
        chk(ras_n, 4'hF);
        chk(addr, 9'h004);
        // Mode 4 access on the last table row, then mode 0 refresh
        {mh, ml, pclk, wr_n, rin_n} <= 5'h14;
        tick(2);
        chk(ras_n, 4'h7);
        chk(addr, 9'h123);
        chk(we_n, 1'b0);
        pclk <= 1'b0;
        tick(2);
        chk(addr, 9'h0F0);
        chk(cas_n, 1'b0);
        {mh, pclk, rin_n} <= 3'h3;
        tick(2);
        chk(addr, 9'h004);
        chk(oe, 1'b0);
        rin_n <= 1'b0;
        tick(2);
        chk(ras_n, 4'h0);
        // Closed latch must keep showing the last open value
        {mh, ml, pclk, rin_n} <= 4'hD;
        row <= 9'h155;
        tick(1);
        lat <= 1'b0;
        row <= 9'h0AA;
        tick(2);
        chk(addr, 9'h155);
        lat <= 1'b1;
        tick(2);
        chk(addr, 9'h0AA);
        stop_test();
    end
endmodule // dramc_ctrl_tb_top
